// *** logic/cadc_channel_config.sv ***
// Per-channel converter and digital input configuration with edge counters
`timescale 1ns/1ps
`default_nettype none
module cadc_channel_config #(
  parameter int UNIT_CYC = cadc_pkg::DEB_UNIT_CYC
) (
  // Clock and synchronous reset
  input  wire logic                         MCLK,
  input  wire logic                         SYS_RST,
  // Register port
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  input  wire logic [7:0]                   REG_ADDR,
  input  wire logic [15:0]                  REG_WDATA,
  output var  logic [15:0]                  REG_RDATA,
  // Notice of a channel function write
  input  wire logic                         FUNC_WR,
  input  wire logic [1:0]                   FUNC_CH,
  input  wire logic [3:0]                   FUNC_CODE,
  // Raw comparator outputs, not yet synchronised
  input  wire logic [cadc_pkg::NCH-1:0]     COMP_RAW,
  // Configuration fields and filtered levels
  output var  logic [3*cadc_pkg::NCH-1:0]   CONV_SPAN,
  output var  logic [3*cadc_pkg::NCH-1:0]   CONV_INPUT_SEL,
  output var  logic [4*cadc_pkg::NCH-1:0]   CONV_RATE,
  output var  logic [cadc_pkg::NCH-1:0]     COMP_EN,
  output var  logic [cadc_pkg::NCH-1:0]     SINK_RANGE,
  output var  logic [5*cadc_pkg::NCH-1:0]   SINK_CODE,
  output var  logic [cadc_pkg::NCH-1:0]     DIN_LEVEL
);
  import cadc_pkg::*;

  // Register state per channel
  logic [15:0]     adc_reg   [NCH];
  logic [15:0]     adc_next  [NCH];
  logic [15:0]     din_reg   [NCH];
  logic [15:0]     din_next  [NCH];
  logic [15:0]     cnt_reg   [NCH];
  logic [15:0]     cnt_next  [NCH];

  // Level tracking, synchroniser and filter connections
  logic [NCH-1:0]  prev_reg,  prev_next;
  logic [NCH-1:0]  lvl_reg,   lvl_next;
  logic [NCH-1:0]  s1_reg,    s2_reg;
  logic [NCH-1:0]  deb_out;
  logic [NCH-1:0]  deb_in;

  // Read data and debounce time unit divider
  logic [15:0]     rd_reg,    rd_next;
  logic [15:0]     div_reg,   div_next;
  logic            tick_reg,  tick_next;

  // Two-stage synchroniser for the comparator outputs
  // Only the second stage is read; the first may still be settling
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= COMP_RAW;
      s2_reg <= s1_reg;
    end
  end

  // Debounce time unit divider
  // One divider serves every filter, so all channels share one tick phase
  always_comb begin
    div_next  = div_reg + 16'h0001;
    tick_next = 1'b0;
    if (div_reg >= 16'(UNIT_CYC - 1)) begin
      div_next  = 16'h0000;
      tick_next = 1'b1;
    end
  end

  // Divider registers
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  // Debounce filters, fed with the optionally inverted comparator output
  // Inversion sits before the filter, so the edge counter sees the inverted level
  for (genvar g = 0; g < NCH; g++) begin : g_deb
    assign deb_in[g] = s2_reg[g] ^ din_reg[g][INV_BIT];
    cadc_debounce u_deb (
      .clk       (MCLK),
      .rst       (SYS_RST),
      .unit_tick (tick_reg),
      .din       (deb_in[g]),
      .mode      (din_reg[g][DEB_MODE_BIT]),
      .limit     (din_reg[g][DEB_TIME_LSB +: 5]),
      .dout      (deb_out[g])
    );
  end

  // Configuration registers; the function write is applied after the bus
  // write so it wins on the fields it reloads, while the rest of a
  // same-cycle bus write still lands
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      adc_next[c] = adc_reg[c];
      din_next[c] = din_reg[c];
      if (REG_WR && REG_ADDR == chan_addr(ADC_BASE, c)) begin
        adc_next[c] = REG_WDATA & ADC_WMASK;
      end else if (REG_WR && REG_ADDR == chan_addr(DIN_BASE, c)) begin
        din_next[c] = REG_WDATA & DIN_WMASK;
      end
      if (FUNC_WR && FUNC_CH == 2'(c)) begin
        adc_next[c][INSEL_LSB +: 3] = fn_insel(FUNC_CODE);
        din_next[c][CMP_EN_BIT]     = fn_cmp_en(FUNC_CODE);
        din_next[c][SINK_LSB +: 5]  = 5'h00;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      for (int c = 0; c < NCH; c++) begin
        adc_reg[c] <= ADC_RESET;
        din_reg[c] <= DIN_RESET;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        adc_reg[c] <= adc_next[c];
        din_reg[c] <= din_next[c];
      end
    end
  end

  // Edge counters on the filtered level; they wrap at 16 bits and only
  // reset clears them. The previous level resets low like the filter
  // output, so no false edge is counted after reset.
  always_comb begin
    prev_next = deb_out;
    for (int c = 0; c < NCH; c++) begin
      cnt_next[c] = cnt_reg[c];
      if (din_reg[c][CNT_EN_BIT]) begin
        if (din_reg[c][INV_BIT] ? (prev_reg[c] && !deb_out[c])
                                : (!prev_reg[c] && deb_out[c])) begin
          cnt_next[c] = cnt_reg[c] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_reg[c] <= 16'h0000;
      end
      prev_reg <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        cnt_reg[c] <= cnt_next[c];
      end
      prev_reg <= prev_next;
    end
  end

  // Registered copy of the filtered level that drives the level pins
  always_comb begin
    lvl_next = deb_out;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      lvl_reg <= '0;
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads zero
  // A read in the same cycle as a write returns the old value
  always_comb begin
    rd_next = rd_reg;
    if (REG_RD) begin
      rd_next = 16'h0000;
      for (int c = 0; c < NCH; c++) begin
        if (REG_ADDR == chan_addr(ADC_BASE, c)) begin
          rd_next = adc_reg[c];
        end else if (REG_ADDR == chan_addr(DIN_BASE, c)) begin
          rd_next = din_reg[c];
        end else if (REG_ADDR == CNT_BASE + 8'(c)) begin
          rd_next = cnt_reg[c];
        end
      end
    end
  end

  // Read data register, held until the next read strobe
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rd_reg <= 16'h0000;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // Outputs straight from the configuration flip-flops
  // Each field is a plain slice of register bits, with no logic in between
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      CONV_SPAN[3*c +: 3]      = adc_reg[c][SPAN_LSB +: 3];
      CONV_INPUT_SEL[3*c +: 3] = adc_reg[c][INSEL_LSB +: 3];
      CONV_RATE[4*c +: 4]      = adc_reg[c][RATE_LSB +: 4];
      COMP_EN[c]               = din_reg[c][CMP_EN_BIT];
      SINK_RANGE[c]            = din_reg[c][SINK_RNG_BIT];
      SINK_CODE[5*c +: 5]      = din_reg[c][SINK_LSB +: 5];
    end
  end

  // Level and read data pins
  assign DIN_LEVEL = lvl_reg;
  assign REG_RDATA = rd_reg;
endmodule : cadc_channel_config
`default_nettype wire

// *** logic/cadc_pkg.sv ***
// Constants and helpers shared by the channel configuration block
//
// Summary of operation
// - Span codes 101 to 111 select low ranges
// - Input select routes one node pair
// - Function write overwrites converter input select
// - Count rising edges, falling when inverted
// - Edge count readable in counter register
// - Invert comparator output before debounce
// - Comparator enable; function write may rewrite
// - Sink range bit selects step size
// - Five-bit sink code; zero turns off
// - Function write clears sink current code
// - Mode zero integrates up and down
// - Mode one counts up, clears on deassert
// - Debounce time field, reset 0xB, zero bypasses
// - Digital config per channel, 0x03 step 12
// - Converter setup per channel, 0x02 step 12
// - Span codes 000 to 100 select high ranges
package cadc_pkg;

  localparam int          NCH           = 4;
  localparam logic [7:0]  CH_STRIDE     = 8'h0c;
  localparam logic [7:0]  ADC_BASE      = 8'h02;
  localparam logic [7:0]  DIN_BASE      = 8'h03;
  localparam logic [7:0]  CNT_BASE      = 8'h30;

  localparam logic [15:0] ADC_RESET     = 16'h0100;
  localparam logic [15:0] DIN_RESET     = 16'h000b;
  localparam logic [15:0] ADC_WMASK     = 16'h0f77;
  localparam logic [15:0] DIN_WMASK     = 16'hffdf;

  // Converter setup fields
  localparam int          RATE_LSB      = 8;
  localparam int          SPAN_LSB      = 4;
  localparam int          INSEL_LSB     = 0;

  // Digital input setup fields
  localparam int          CNT_EN_BIT    = 15;
  localparam int          INV_BIT       = 14;
  localparam int          CMP_EN_BIT    = 13;
  localparam int          SINK_RNG_BIT  = 12;
  localparam int          SINK_LSB      = 7;
  localparam int          DEB_MODE_BIT  = 6;
  localparam int          DEB_TIME_LSB  = 0;

  // Node pair codes for the converter input select
  localparam logic [2:0]  INSEL_LOW_GND = 3'h0;
  localparam logic [2:0]  INSEL_HI_LOW  = 3'h1;

  // Channel function codes that matter here
  localparam logic [3:0]  FN_RESISTANCE = 4'h7;
  localparam logic [3:0]  FN_DIN_LOGIC  = 4'h8;
  localparam logic [3:0]  FN_DIN_LOOP   = 4'h9;

  // One debounce time unit; code 0xB gives about 240 us
  localparam int          CLK_NS        = 100;
  localparam int          DEB_UNIT_NS   = 21818;
  localparam int          DEB_UNIT_CYC  = (DEB_UNIT_NS + CLK_NS - 1) / CLK_NS;

  // Address of a per-channel register
  function automatic logic [7:0] chan_addr(input logic [7:0] base, input int ch);
    chan_addr = base + 8'(ch) * CH_STRIDE;
  endfunction : chan_addr

  // Input select loaded by a channel function write
  function automatic logic [2:0] fn_insel(input logic [3:0] fn);
    fn_insel = (fn == FN_RESISTANCE) ? INSEL_HI_LOW : INSEL_LOW_GND;
  endfunction : fn_insel

  // Comparator enable loaded by a channel function write
  function automatic logic fn_cmp_en(input logic [3:0] fn);
    fn_cmp_en = (fn == FN_DIN_LOGIC) || (fn == FN_DIN_LOOP);
  endfunction : fn_cmp_en

endpackage : cadc_pkg

// *** logic/cadc_debounce.sv ***
// Debounce filter for one digital input channel
`timescale 1ns/1ps
`default_nettype none
module cadc_debounce (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       unit_tick,
  input  wire logic       din,
  input  wire logic       mode,
  input  wire logic [4:0] limit,
  output var  logic       dout
);
  logic [4:0] cnt_reg,  cnt_next;
  logic       out_reg,  out_next;

  // Counter and output level update
  always_comb begin
    cnt_next = cnt_reg;
    out_next = out_reg;
    if (limit == 5'h00) begin
      cnt_next = 5'h00;
      out_next = din;
    end else if (mode && !din) begin
      cnt_next = 5'h00;
      out_next = 1'b0;
    end else if (unit_tick) begin
      if (din && cnt_reg < limit) begin
        cnt_next = cnt_reg + 5'h01;
      end else if (!din && cnt_reg != 5'h00) begin
        cnt_next = cnt_reg - 5'h01;
      end
      if (din && cnt_next >= limit) begin
        out_next = 1'b1;
      end else if (!din && cnt_next == 5'h00) begin
        out_next = 1'b0;
      end
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 5'h00;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule : cadc_debounce
`default_nettype wire

// *** logic/unused_placeholder_none.sv ***
// Intentionally empty design note file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** test/cadc_config_props.sv ***
// Port assertions for the channel configuration block
`timescale 1ns/1ps
`default_nettype none
module cadc_config_props (
  input wire logic        MCLK,
  input wire logic        SYS_RST,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  input wire logic        FUNC_WR,
  input wire logic [1:0]  FUNC_CH,
  input wire logic [3:0]  FUNC_CODE,
  input wire logic [11:0] CONV_SPAN,
  input wire logic [11:0] CONV_INPUT_SEL,
  input wire logic [15:0] CONV_RATE,
  input wire logic [3:0]  COMP_EN,
  input wire logic [19:0] SINK_CODE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // Channel function write seen at an edge
  sequence s_fn;
    FUNC_WR;
  endsequence
  // Reset state and register paths
  a_reset_state: assert property (disable iff (1'b0) SYS_RST |=> CONV_RATE == 16'h1111
    && SINK_CODE == 20'h0) else $error("bad state after reset");
  a_span_write: assert property (REG_WR && REG_ADDR == 8'h02 |=>
    CONV_SPAN[2:0] == $past(REG_WDATA[6:4])) else $error("span not written");
  a_insel_write: assert property (REG_WR && REG_ADDR == 8'h02 && !FUNC_WR |=>
    CONV_INPUT_SEL[2:0] == $past(REG_WDATA[2:0])) else $error("input select not written");
  a_sink_write: assert property (REG_WR && REG_ADDR == 8'h03 && !FUNC_WR |=>
    SINK_CODE[4:0] == $past(REG_WDATA[11:7]) && COMP_EN[0] == $past(REG_WDATA[13]))
    else $error("sink code not written");
  a_fn_insel: assert property (s_fn |=> CONV_INPUT_SEL[3*$past(FUNC_CH)+:3] ==
    (($past(FUNC_CODE) == 4'h7) ? 3'h1 : 3'h0)) else $error("input select not reloaded");
  a_fn_comp: assert property (s_fn |=> COMP_EN[$past(FUNC_CH)] ==
    ($past(FUNC_CODE) inside {4'h8, 4'h9})) else $error("comparator enable not reloaded");
  a_fn_sink: assert property (s_fn |=> SINK_CODE[5*$past(FUNC_CH)+:5] == 5'h00)
    else $error("sink code not cleared");
  a_unmapped_zero: assert property (REG_RD && REG_ADDR == 8'h01 |=> REG_RDATA == 16'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without read");
endmodule : cadc_config_props
`default_nettype wire

// *** test/cadc_channel_config_test.sv ***
// Register level testbench for the channel configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module cadc_channel_config_test;
  import cadc_pkg::*;
  logic        MCLK = 0, SYS_RST = 1, REG_WR = 0, REG_RD = 0, FUNC_WR = 0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, CONV_RATE;
  logic [1:0]  FUNC_CH = 2'h0;
  logic [3:0]  FUNC_CODE = 4'h0, COMP_RAW = 4'h0, COMP_EN, SINK_RANGE, DIN_LEVEL;
  logic [11:0] CONV_SPAN, CONV_INPUT_SEL;
  logic [19:0] SINK_CODE;
  logic [3:0]  codes [3] = '{4'h7, 4'h8, 4'h0};
  int          n_fail = 0, tests_run = 0;
  cadc_channel_config #(.UNIT_CYC(2)) DUT (.MCLK(MCLK), .SYS_RST(SYS_RST), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .FUNC_WR(FUNC_WR), .FUNC_CH(FUNC_CH), .FUNC_CODE(FUNC_CODE), .COMP_RAW(COMP_RAW),
    .CONV_SPAN(CONV_SPAN), .CONV_INPUT_SEL(CONV_INPUT_SEL), .CONV_RATE(CONV_RATE),
    .COMP_EN(COMP_EN), .SINK_RANGE(SINK_RANGE), .SINK_CODE(SINK_CODE), .DIN_LEVEL(DIN_LEVEL));
  // Clock at 100 ns
  always #50 MCLK = ~MCLK;
  // Wait edges, then settle
  task tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : tick
  task wr(input logic [7:0] a, input logic [15:0] d);
    {REG_WR, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    tick(1);
    REG_WR = 0;
    tick(1);
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    {REG_RD, REG_ADDR} = {1'b1, a};
    tick(1);
    REG_RD = 0;
    `CHK(REG_RDATA, e)
    tick(1);
  endtask : rd
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    tick(12);
    SYS_RST = 0;
    for (int c = 0; c < 4; c++) begin
      rd(8'(2 + 12 * c), 16'h0100);
      rd(8'(3 + 12 * c), 16'h000b);
      rd(8'(8'h30 + c), 16'h0000);
    end
    rd(8'h01, 16'h0000);
    wr(8'h02, 16'hffff);
    rd(8'h02, 16'h0f77);
    wr(8'h03, 16'hffff);
    rd(8'h03, 16'hffdf);
    `CHK({COMP_EN[0], SINK_RANGE[0], SINK_CODE[4:0]}, 7'h7f)
    for (int i = 0; i < 8; i++) begin
      wr(8'h0e, {9'h0, 3'(i), 1'b0, 3'(i % 5)});
      `CHK(CONV_SPAN[5:3], 3'(i))
      `CHK(CONV_INPUT_SEL[5:3], 3'(i % 5))
    end
    // Function writes on channel 2 reload fields
    for (int k = 0; k < 3; k++) begin
      wr(8'h1b, 16'h2f80);
      wr(8'h1a, 16'h0004);
      {FUNC_WR, FUNC_CH, FUNC_CODE} = {1'b1, 2'h2, codes[k]};
      tick(1);
      FUNC_WR = 0;
      `CHK(CONV_INPUT_SEL[8:6], 3'(codes[k] == 4'h7))
      `CHK(COMP_EN[2], codes[k][3])
      `CHK(SINK_CODE[14:10], 5'h00)
    end
    // Bypassed filter with edge counting on channel 3
    wr(8'h27, 16'h8000);
    repeat (3) begin
      COMP_RAW[3] = 1;
      tick(6);
      `CHK(DIN_LEVEL[3], 1'b1)
      COMP_RAW[3] = 0;
      tick(6);
    end
    rd(8'h33, 16'h0003);
    wr(8'h27, 16'hc000);
    tick(6);
    `CHK(DIN_LEVEL[3], 1'b1)
    COMP_RAW[3] = 1;
    tick(6);
    `CHK(DIN_LEVEL[3], 1'b0)
    rd(8'h33, 16'h0004);
    // Same short dip under both filter modes
    for (int m = 0; m < 2; m++) begin
      COMP_RAW[3] = 1;
      wr(8'h27, {9'h0, 1'(m), 6'h03});
      tick(3);
      `CHK(DIN_LEVEL[3], 1'b0)
      tick(20);
      `CHK(DIN_LEVEL[3], 1'b1)
      COMP_RAW[3] = 0;
      tick(2);
      COMP_RAW[3] = 1;
      tick(5);
      `CHK(DIN_LEVEL[3], m == 0)
      COMP_RAW[3] = 0;
      tick(20);
      `CHK(DIN_LEVEL[3], 1'b0)
    end
    give_verdict();
  end
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
endmodule : cadc_channel_config_test
bind cadc_channel_config cadc_config_props u_props (.MCLK(MCLK), .SYS_RST(SYS_RST),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .FUNC_WR(FUNC_WR), .FUNC_CH(FUNC_CH), .FUNC_CODE(FUNC_CODE),
  .CONV_SPAN(CONV_SPAN), .CONV_INPUT_SEL(CONV_INPUT_SEL), .CONV_RATE(CONV_RATE),
  .COMP_EN(COMP_EN), .SINK_CODE(SINK_CODE));
`default_nettype wire
